/* hdl/jsc_defs.svh */
/*
  Frame geometry and fixed stuff counts for the justification control block.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef JSC_DEFS_SVH
`define JSC_DEFS_SVH

// ==========================================================================
// server frame geometry
`define JSC_ROWS 4
`define JSC_ODU_COLS 3824
`define JSC_OPU_COLS 3808
`define JSC_FRAME_BYTES (`JSC_ROWS * `JSC_ODU_COLS)
`define JSC_PAYLOAD_BYTES (`JSC_ROWS * `JSC_OPU_COLS)

// ==========================================================================
// fixed stuff bytes per client payload area
`define JSC_FS_CBR2G5 0
`define JSC_FS_CBR10G 64
`define JSC_FS_CBR40G 128
`define JSC_FS_ODU1_3 4

// ==========================================================================
// default elastic buffer depth and fill thresholds
`define JSC_DEPTH_W 8
`define JSC_FILL_HI 192
`define JSC_FILL_LO 64
`define JSC_FILL_LO2 32

`endif

/* hdl/jsc_pkg.sv */
/*
  Types shared by the justification control block: mapping modes and the
  signed justification value.
  Assumes nothing of its surroundings.
*/
package jsc_pkg;

  // ========================================================================
  // mapping modes: three cbr mappings and four multiplexing cases
  typedef enum logic [2:0] {
    JSC_M_CBR2G5,
    JSC_M_CBR10G,
    JSC_M_CBR40G,
    JSC_M_ODU0_1,
    JSC_M_ODU1_2,
    JSC_M_ODU2_3,
    JSC_M_ODU1_3
  } jsc_mode_t;

  // justification value: +1 extra byte carried, -1/-2 bytes skipped
  typedef logic signed [1:0] jsc_alpha_t;

endpackage

/* hdl/jsc_fill_mon.sv */
/*
  Client elastic buffer fill tracker.
  Assumes client writes and server reads arrive on clk_sys as one-cycle
  strobes from logic in the same clock domain.
*/
`timescale 1ns/1ps
module jsc_fill_mon #(
  parameter int DEPTH_W = 8 // log2 of buffer depth
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic wr, // client byte written
  input wire logic rd, // server byte taken
  output logic [DEPTH_W:0] fill, // bytes held
  output logic full // no room for a client byte
);

  // ========================================================================
  // occupancy
  localparam logic [DEPTH_W:0] DEPTH = (DEPTH_W+1)'(1 << DEPTH_W);
  wire empty = (fill == '0);
  wire do_wr = wr && !full;
  wire do_rd = rd && !empty;
  logic [DEPTH_W:0] next_fill;

  assign full = (fill == DEPTH);
  // a read from empty or a write into full is dropped, never wraps
  assign next_fill = (do_wr && !do_rd) ? fill + 1'b1 :
                     (do_rd && !do_wr) ? fill - 1'b1 : fill;

  // fill register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fill <= '0;
    end else begin
      fill <= next_fill;
    end
  end

  // ========================================================================
  // checks
  a_fill_limit: assert property (@(posedge clk_sys) disable iff (!nrst)
    fill <= DEPTH) else $error("fill above depth");
  a_fill_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && !full && !rd) |=> fill == $past(fill) + 1'b1)
    else $error("write did not raise fill");
  // a read alone must lower the fill, a write into full must not count
  a_fill_drain: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rd && !wr && !empty) |=> fill == $past(fill) - 1'b1)
    else $error("read did not lower fill");
  a_full_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr && full && !rd) |=> fill == $past(fill))
    else $error("write into full buffer counted");

endmodule

/* hdl/jsc_stuff_ctrl.sv */
/*
  Justification control for asynchronous cbr mapping and odu multiplexing.
  Counts server byte slots into frames, owns a share of the justification
  opportunities, and decides per owned opportunity from the client fill.
  Assumes the server frame generator strobes srv_tick once per frame byte
  slot and srv_rd once per client byte it takes, all on clk_sys.
*/
`timescale 1ns/1ps
`include "jsc_defs.svh"

// Behaviour
// - cbr: one positive, one negative opportunity/frame
// - multiplexing: up to two positive, one negative
// - single cbr client uses every frame's opportunity
// - tributary uses only its 1/2, 1/4, 1/16 share
// - alpha within -1..1 cbr, -2..1 multiplexing
// - fixed stuff 0, 64, 128 per cbr mapping
// - client payload 4x3808 bytes scaled, adjusted
// - server frame is 4 rows of 3824
module jsc_stuff_ctrl #(
  parameter int DEPTH_W = `JSC_DEPTH_W, // log2 of client buffer depth
  parameter int FILL_HI = `JSC_FILL_HI, // at or above: carry extra byte
  parameter int FILL_LO = `JSC_FILL_LO, // below: skip one byte
  parameter int FILL_LO2 = `JSC_FILL_LO2 // below, multiplexing: skip two
) (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic nrst, // synchronous reset, active low
  input jsc_pkg::jsc_mode_t mode, // mapping mode
  input wire logic [3:0] trib_id, // tributary index within the server
  input wire logic cli_valid, // client byte offered
  output logic cli_ready, // client byte accepted when valid
  input wire logic srv_tick, // one server frame byte slot
  input wire logic srv_rd, // server takes one client byte
  output logic frame_sof, // pulse: a new server frame begins
  output logic jc_valid, // pulse with frame_sof: opportunity owned
  output jsc_pkg::jsc_alpha_t jc_alpha, // justification for that frame
  output logic [13:0] frame_bytes, // client bytes to carry this frame
  output logic [DEPTH_W:0] fill_level // client buffer fill
);
  import jsc_pkg::*;

  // ========================================================================
  // mode decoding
  // share of opportunities as a right shift: 1, 1/2, 1/4, 1/16
  function automatic logic [2:0] share_shift(input jsc_mode_t m);
    unique case (m)
      JSC_M_ODU0_1: share_shift = 3'h1;
      JSC_M_ODU1_2, JSC_M_ODU2_3: share_shift = 3'h2;
      JSC_M_ODU1_3: share_shift = 3'h4;
      default: share_shift = 3'h0; // cbr modes and unused code
    endcase
  endfunction

  function automatic logic is_mux(input jsc_mode_t m);
    is_mux = (m == JSC_M_ODU0_1) || (m == JSC_M_ODU1_2) ||
             (m == JSC_M_ODU2_3) || (m == JSC_M_ODU1_3);
  endfunction

  // fixed stuff bytes belonging to this client
  function automatic logic [7:0] fixed_stuff(input jsc_mode_t m);
    unique case (m)
      JSC_M_CBR2G5: fixed_stuff = 8'(`JSC_FS_CBR2G5);
      JSC_M_CBR10G: fixed_stuff = 8'(`JSC_FS_CBR10G);
      JSC_M_CBR40G: fixed_stuff = 8'(`JSC_FS_CBR40G);
      JSC_M_ODU1_3: fixed_stuff = 8'(`JSC_FS_ODU1_3);
      default: fixed_stuff = 8'h00;
    endcase
  endfunction

  // ========================================================================
  // client elastic buffer fill
  logic cli_full;

  jsc_fill_mon #(
    .DEPTH_W(DEPTH_W)
  ) u_fill (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wr(cli_valid),
    .rd(srv_rd),
    .fill(fill_level),
    .full(cli_full)
  );

  // back-pressure toward the client source
  assign cli_ready = !cli_full;

  // ========================================================================
  // server frame counting
  localparam logic [13:0] FRAME_LAST = 14'(`JSC_FRAME_BYTES - 1);
  localparam logic [13:0] PAYLOAD = 14'(`JSC_PAYLOAD_BYTES);

  logic [13:0] byte_cnt;
  logic [3:0] mf_cnt;
  wire frame_wrap = srv_tick && (byte_cnt == FRAME_LAST);
  wire [13:0] next_byte_cnt = frame_wrap ? 14'h0000 :
                              srv_tick ? byte_cnt + 14'h0001 : byte_cnt;
  wire [3:0] next_mf_cnt = frame_wrap ? mf_cnt + 4'h1 : mf_cnt;

  // byte slot and frame index counters
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      byte_cnt <= 14'h0000;
      mf_cnt <= 4'h0;
    end else begin
      byte_cnt <= next_byte_cnt;
      mf_cnt <= next_mf_cnt;
    end
  end

  // ========================================================================
  // opportunity ownership and decision
  // the frame index modulo the share picks the tributary that owns it
  wire [2:0] shift = share_shift(mode);
  wire [3:0] share_mask = 4'((5'h01 << shift) - 5'h01);
  wire owned = ((next_mf_cnt & share_mask) == (trib_id & share_mask));
  wire mux = is_mux(mode);

  // thresholds held at the fill width so the compares stay exact
  wire [DEPTH_W:0] th_hi = (DEPTH_W+1)'(FILL_HI);
  wire [DEPTH_W:0] th_lo = (DEPTH_W+1)'(FILL_LO);
  wire [DEPTH_W:0] th_lo2 = (DEPTH_W+1)'(FILL_LO2);

  // high fill: carry an extra byte; low fill: leave bytes out.
  // skip-two only exists when multiplexing, so cbr stays within -1..1
  wire jsc_alpha_t next_alpha =
    (fill_level >= th_hi) ? 2'sd1 :
    (mux && fill_level < th_lo2) ? -2'sd2 :
    (fill_level < th_lo) ? -2'sd1 :
    2'sd0;

  // client bytes in this frame: share of payload, less fixed stuff,
  // adjusted by the justification when this client owns the frame
  wire [13:0] base_bytes = PAYLOAD >> shift;
  wire signed [15:0] adj = owned ? 16'(next_alpha) : 16'sh0000;
  wire signed [15:0] sum_bytes = $signed({2'b00, base_bytes}) -
                                 $signed({8'h00, fixed_stuff(mode)}) + adj;

  // decision registers, updated once per frame boundary
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      frame_sof <= 1'b0;
      jc_valid <= 1'b0;
      jc_alpha <= 2'sd0;
      frame_bytes <= 14'h0000;
    end else begin
      frame_sof <= frame_wrap;
      jc_valid <= frame_wrap && owned;
      if (frame_wrap) begin
        jc_alpha <= owned ? next_alpha : 2'sd0;
        frame_bytes <= sum_bytes[13:0];
      end
    end
  end

  // ========================================================================
  // checks
  // full buffer depth, kept here so the ready check does not lean on the
  // fill tracker's own full flag
  localparam logic [DEPTH_W:0] BUF_DEPTH = (DEPTH_W+1)'(1 << DEPTH_W);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // frame geometry: a start pulse only after the last slot of a frame
  a_sof_period: assert property (frame_sof |->
    byte_cnt == 14'h0000 && $past(byte_cnt) == FRAME_LAST)
    else $error("frame not 15296 slots");
  // the frame result stands until the next frame start
  a_hold_frame: assert property (!frame_sof |->
    $stable(jc_alpha) && $stable(frame_bytes))
    else $error("frame result changed mid-frame");

  // ownership of the opportunity: every frame for cbr, a share when
  // multiplexing, and nothing applied on frames owned by others
  a_valid_on_sof: assert property (jc_valid |-> frame_sof)
    else $error("decision outside frame start");
  a_cbr_every: assert property ((frame_sof && !$past(mux)) |-> jc_valid)
    else $error("cbr frame without opportunity");
  a_share_own: assert property (jc_valid |->
    ((mf_cnt & $past(share_mask)) == ($past(trib_id) & $past(share_mask))))
    else $error("opportunity outside tributary share");
  a_unowned_zero: assert property ((frame_sof && !jc_valid) |->
    jc_alpha == 2'sd0)
    else $error("justification on a frame not owned");

  // justification value against its range and the fill that chose it
  a_cbr_range: assert property ((jc_valid && !$past(mux)) |->
    jc_alpha != -2'sd2)
    else $error("cbr alpha below -1");
  a_two_pos_mux: assert property ((jc_valid && jc_alpha == -2'sd2) |->
    $past(mux))
    else $error("skip-two outside multiplexing");
  a_neg_hi: assert property ((jc_valid && jc_alpha == 2'sd1) |->
    $past(fill_level) >= $past(th_hi))
    else $error("extra byte without high fill");
  a_pos_lo: assert property ((jc_valid && jc_alpha[1]) |->
    $past(fill_level) < $past(th_lo))
    else $error("skip without low fill");
  a_skip_two_low: assert property ((jc_valid && jc_alpha == -2'sd2) |->
    $past(fill_level) < $past(th_lo2))
    else $error("skip-two without very low fill");
  a_zero_mid: assert property ((jc_valid && jc_alpha == 2'sd0) |->
    $past(fill_level) >= $past(th_lo) && $past(fill_level) < $past(th_hi))
    else $error("no justification outside the mid band");

  // client byte counts per frame: share, less fixed stuff, plus alpha
  a_bytes_10g: assert property ((frame_sof && $past(mode) == JSC_M_CBR10G) |->
    frame_bytes == 14'(16'(`JSC_PAYLOAD_BYTES - `JSC_FS_CBR10G) + 16'(jc_alpha)))
    else $error("cbr10g payload count wrong");
  a_bytes_40g: assert property ((frame_sof && $past(mode) == JSC_M_CBR40G) |->
    frame_bytes == 14'(16'(`JSC_PAYLOAD_BYTES - `JSC_FS_CBR40G) + 16'(jc_alpha)))
    else $error("cbr40g payload count wrong");
  a_bytes_odu13: assert property ((frame_sof && $past(mode) == JSC_M_ODU1_3) |->
    frame_bytes == 14'(16'((`JSC_PAYLOAD_BYTES >> 4) - `JSC_FS_ODU1_3) + 16'(jc_alpha)))
    else $error("sixteenth share payload count wrong");

  // back-pressure follows the fill: ready drops only at full depth
  a_ready_full: assert property (cli_ready == (fill_level != BUF_DEPTH))
    else $error("ready disagrees with fill");

  // main scenarios
  c_neg_just: cover property (jc_valid && jc_alpha == 2'sd1);
  c_pos_one: cover property (jc_valid && jc_alpha == -2'sd1);
  c_pos_two: cover property (jc_valid && jc_alpha == -2'sd2);
  c_not_owned: cover property (frame_sof && !jc_valid);
  c_zero_owned: cover property (jc_valid && jc_alpha == 2'sd0);

endmodule

/* test/jsc_srv_gen.sv */
/*
  Server frame generator stand-in: one frame byte slot every clock and
  client byte reads on request.
  Assumes clk_sys and nrst come from the bench, rd_req changes at negedge.
*/
`timescale 1ns/1ps
module jsc_srv_gen (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic rd_req, // bench asks for a byte read
  output logic srv_tick, // frame byte slot
  output logic srv_rd // client byte taken
);
  // ==========================================================================
  // slot and read strobes
  // a slot every cycle keeps frames short; rd_req seen one negedge late
  // one driver per strobe; the unknown before the first negedge falls
  // inside reset and is never used
  always @(negedge clk_sys) begin
    srv_tick <= nrst;
    srv_rd <= nrst & rd_req;
  end
endmodule

/* test/jsc_stuff_ctrl_tb.sv */
/*
  Self-checking bench for the justification control block.
  Assumes the design files and jsc_srv_gen are compiled first.
*/
`timescale 1ns/1ps
module jsc_stuff_ctrl_tb;
  import jsc_pkg::*;
  // ==========================================================================
  // signals and bookkeeping
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  jsc_mode_t mode = JSC_M_CBR2G5;
  logic [3:0] trib_id = 4'h0;
  logic cli_valid = 1'b0;
  logic rd_req = 1'b0;
  logic cli_ready, srv_tick, srv_rd, frame_sof, jc_valid;
  jsc_alpha_t jc_alpha;
  logic [13:0] frame_bytes;
  logic [8:0] fill_level;
  logic [16:0] exp_q[$];
  logic [31:0] lfsr = 32'hce56e630;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int last_sof = -1;
  int cur = 0;

  // 25 MHz clock and a cycle count for frame spacing
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc++;

  jsc_stuff_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .mode(mode), .trib_id(trib_id),
    .cli_valid(cli_valid), .cli_ready(cli_ready), .srv_tick(srv_tick), .srv_rd(srv_rd),
    .frame_sof(frame_sof), .jc_valid(jc_valid), .jc_alpha(jc_alpha),
    .frame_bytes(frame_bytes), .fill_level(fill_level));
  jsc_srv_gen u_srv (.clk_sys(clk_sys), .nrst(nrst), .rd_req(rd_req), .srv_tick(srv_tick),
    .srv_rd(srv_rd));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [16:0] e, input logic [16:0] g, input string what);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s exp %h got %h", $time, what, e, g);
    end
  endtask

  // moves the buffer fill one direction only, never writes and reads together
  task automatic set_fill(input int target);
    if (target > cur) repeat (target - cur) @(negedge clk_sys) cli_valid <= 1'b1;
    else repeat (cur - target) @(negedge clk_sys) rd_req <= 1'b1;
    @(negedge clk_sys);
    cli_valid <= 1'b0;
    rd_req <= 1'b0;
    cur = target;
    repeat (3) @(negedge clk_sys);
    check(17'(target), 17'(fill_level), "fill level");
    check(17'(target != 256), 17'(cli_ready), "ready level");
  endtask

  // one server frame: mode, tributary, fill at the wrap, expected result
  task automatic frame(input jsc_mode_t m, input logic [3:0] t, input int f,
                       input logic [16:0] e);
    mode <= m;
    trib_id <= t;
    exp_q.push_back(e);
    set_fill(f);
    if (f == 256) begin
      check(17'h0, 17'(cli_ready), "ready while full");
      cur = 255;
      set_fill(256);
    end
    @(posedge frame_sof);
    @(negedge clk_sys);
    $display("frame test done, mode %0d", m);
  endtask

  // ==========================================================================
  // result monitor: frame outputs against the oldest note, and frame spacing
  always @(negedge clk_sys) begin
    if (frame_sof === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("CHECK FAILED t=%0t frame start with no note", $time);
      end else begin
        check(exp_q.pop_front(), {jc_valid, jc_alpha, frame_bytes}, "frame");
      end
      if (last_sof >= 0) check(17'd15296, 17'(cyc - last_sof), "frame period");
      last_sof = cyc;
    end
  end

  // ==========================================================================
  // closing and watchdog
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // six frames take about 92k cycles
  initial begin
    #(40 * 98000);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    nrst <= 1'b1;
    lfsr = next_rand(lfsr);
    frame(JSC_M_CBR40G, 4'h0, 0, {1'b1, 2'b11, 14'd15103});
    frame(JSC_M_CBR10G, 4'h0, 256, {1'b1, 2'b01, 14'd15169});
    frame(JSC_M_ODU0_1, 4'h1, 64 + int'(lfsr[6:0]), {1'b1, 2'b00, 14'd7616});
    frame(JSC_M_ODU1_2, 4'h1, 20, {1'b0, 2'b00, 14'd3808});
    frame(JSC_M_ODU2_3, 4'h1, 10, {1'b1, 2'b10, 14'd3806});
    frame(JSC_M_ODU1_3, 4'h6, 40, {1'b1, 2'b11, 14'd947});
    stop_test();
  end
endmodule
